// ===== hdl/tone_defs.vh
// Purpose: Constants for the buzzer tone generator
// Assumes: Byte address of a register is four times its index
// Notes: Included by tone_generator.v
`ifndef TONE_DEFS_VH
`define TONE_DEFS_VH

`define IDX_CONTROL 16'hf0c0
`define IDX_RESERVED 16'hf0c1
`define IDX_CONFIG 16'hf0c2

`define BIT_RUN 0
`define BIT_IDLE 12
`define RST_CONTROL 8'h00
`define RST_CONFIG 16'h0000

`define PAT_INTER1 2'h0
`define PAT_INTER2 2'h1
`define PAT_SINGLE 2'h2
`define PAT_CONT 2'h3

`define CLK_HZ 100000000
`define LS_HZ 32768
`define PERIOD_TOP 7'h08
`define PERIOD_STEP 7'h10
`define UNIT_STEP 7'h01

`endif

// ===== hdl/tone_generator.v
// Purpose: Buzzer tone generator with Avalon-MM register slave
// Assumes: Slow ticks are levels synchronous to clock
// Assumes: Clock rate is far above the low-speed rate
// Notes: Low-speed clock is a fractional enable derived from clock
// Notes: One wait state on every register access
// Notes: Software write to run wins over the automatic stop
//
// The Avalon-MM slave port is this design's own decision.
`include "tone_defs.vh"
`timescale 1ns/100ps

module tone_generator #(
  parameter CLK_HZ = `CLK_HZ,
  parameter LS_HZ = `LS_HZ
) (
  input wire clock,
  input wire rst,
  input wire [17:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire tick_eight_hz,
  input wire tick_one_hz,
  output reg tone_out_pos,
  output reg tone_out_neg,
  output reg tone_active
);

////////////////////////////////////////////////////////////////////////////////
// Reset images of the registers

localparam [7:0] CONTROL_RESET = `RST_CONTROL;
localparam [15:0] CONFIG_RESET = `RST_CONFIG;

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [6:0] period_of;
  input [2:0] pitch;
  begin
    if (pitch == 3'h0) begin
      period_of = `PERIOD_TOP;
    end else begin
      period_of = {4'h0, pitch} * `PERIOD_STEP;
    end
  end
endfunction

function [6:0] high_of;
  input [2:0] pitch;
  input [3:0] duty;
  reg [3:0] steps;
  begin
    steps = 4'h0;
    if (pitch == 3'h0) begin
      steps = {1'b0, duty[3:1]};
      if (steps == 4'h0) begin
        steps = 4'h1;
      end
      high_of = {3'h0, steps};
    end else begin
      steps = (duty == 4'h0) ? 4'h1 : duty;
      high_of = {3'h0, steps} * {4'h0, pitch};
    end
  end
endfunction

function reg_is;
  input [15:0] index;
  input [15:0] target;
  begin
    reg_is = (index == target);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Low-speed clock enable

reg [27:0] ls_acc;
reg ls_tick;
wire [27:0] ls_sum;

assign ls_sum = ls_acc + LS_HZ[27:0];

always @(posedge clock) begin
  if (rst) begin
    ls_acc <= 28'h000_0000;
    ls_tick <= 1'b0;
  end else if (ls_sum >= CLK_HZ[27:0]) begin
    ls_acc <= ls_sum - CLK_HZ[27:0];
    ls_tick <= 1'b1;
  end else begin
    ls_acc <= ls_sum;
    ls_tick <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register slave

reg run;
reg [1:0] pattern_sel;
reg [2:0] pitch_sel;
reg [3:0] duty_sel;
reg idle_level_sel;
reg auto_stop;
reg next_run;
reg [1:0] next_pattern_sel;
reg [2:0] next_pitch_sel;
reg [3:0] next_duty_sel;
reg next_idle_level_sel;
reg next_waitrequest;
reg [31:0] next_readdata;
wire [15:0] reg_index;
wire hit_control;
wire hit_config;
wire req;
wire commit_write;
wire write_control;
wire write_config_lo;
wire write_config_hi;
wire [31:0] control_word;
wire [31:0] config_word;

assign reg_index = address[17:2];
assign hit_control = reg_is(reg_index, `IDX_CONTROL);
assign hit_config = reg_is(reg_index, `IDX_CONFIG);
assign req = read | write;
assign commit_write = write & ~waitrequest;
assign write_control = commit_write & hit_control & byteenable[0];
assign write_config_lo = commit_write & hit_config & byteenable[0];
assign write_config_hi = commit_write & hit_config & byteenable[1];
assign control_word = {31'h0000_0000, run};
assign config_word = {
  16'h0000,
  3'h0,
  idle_level_sel,
  duty_sel,
  1'b0,
  pitch_sel,
  2'h0,
  pattern_sel
};

// One wait state: waitrequest drops for the accepting edge only
always @* begin
  next_waitrequest = ~(req & waitrequest);
  next_readdata = readdata;
  if (read & waitrequest) begin
    if (hit_control) begin
      next_readdata = control_word;
    end else if (hit_config) begin
      next_readdata = config_word;
    end else begin
      next_readdata = 32'h0000_0000;
    end
  end
end

always @(posedge clock) begin
  if (rst) begin
    waitrequest <= 1'b1;
    readdata <= 32'h0000_0000;
  end else begin
    waitrequest <= next_waitrequest;
    readdata <= next_readdata;
  end
end

// A software write to run beats the automatic clear in the same cycle
always @* begin
  next_run = run;
  next_pattern_sel = pattern_sel;
  next_pitch_sel = pitch_sel;
  next_duty_sel = duty_sel;
  next_idle_level_sel = idle_level_sel;
  if (write_control) begin
    next_run = writedata[`BIT_RUN];
  end else if (auto_stop) begin
    next_run = 1'b0;
  end
  if (write_config_lo) begin
    next_pattern_sel = writedata[1:0];
    next_pitch_sel = writedata[6:4];
  end
  if (write_config_hi) begin
    next_duty_sel = writedata[11:8];
    next_idle_level_sel = writedata[`BIT_IDLE];
  end
end

always @(posedge clock) begin
  if (rst) begin
    run <= CONTROL_RESET[`BIT_RUN];
    pattern_sel <= CONFIG_RESET[1:0];
    pitch_sel <= CONFIG_RESET[6:4];
    duty_sel <= CONFIG_RESET[11:8];
    idle_level_sel <= CONFIG_RESET[`BIT_IDLE];
  end else begin
    run <= next_run;
    pattern_sel <= next_pattern_sel;
    pitch_sel <= next_pitch_sel;
    duty_sel <= next_duty_sel;
    idle_level_sel <= next_idle_level_sel;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Tone engine, stepped on the low-speed enable

reg [6:0] phase;
reg gate_prev;
reg single_seen;
reg gate;
reg [6:0] next_phase;
reg next_gate_prev;
reg next_single_seen;
reg next_auto_stop;
reg next_tone_active;
reg next_tone_out_pos;
reg next_tone_out_neg;
wire [6:0] period;
wire [6:0] high_len;
wire [6:0] phase_inc;
wire level_now;

assign period = period_of(pitch_sel);
assign high_len = high_of(pitch_sel, duty_sel);
assign phase_inc = phase + `UNIT_STEP;
assign level_now = (phase < high_len) ? ~idle_level_sel : idle_level_sel;

// Single sound plays one joint window of both ticks
always @* begin
  case (pattern_sel)
    `PAT_INTER1: gate = tick_eight_hz;
    `PAT_INTER2: gate = tick_eight_hz & tick_one_hz;
    `PAT_SINGLE: gate = tick_eight_hz & tick_one_hz;
    `PAT_CONT: gate = 1'b1;
    default: gate = 1'b0;
  endcase
end

// A stopped engine parks both pins at the idle level on the next clock
always @* begin
  next_phase = phase;
  next_gate_prev = gate_prev;
  next_single_seen = single_seen;
  next_auto_stop = 1'b0;
  next_tone_active = tone_active;
  next_tone_out_pos = tone_out_pos;
  next_tone_out_neg = tone_out_neg;
  if (~run) begin
    next_phase = 7'h00;
    next_gate_prev = 1'b0;
    next_single_seen = 1'b0;
    next_tone_active = 1'b0;
    next_tone_out_pos = idle_level_sel;
    next_tone_out_neg = idle_level_sel;
  end else if (ls_tick) begin
    next_gate_prev = gate;
    if (gate) begin
      next_tone_active = 1'b1;
      next_tone_out_pos = level_now;
      next_tone_out_neg = ~level_now;
      if (pattern_sel == `PAT_SINGLE) begin
        next_single_seen = 1'b1;
      end
      if (phase_inc >= period) begin
        next_phase = 7'h00;
      end else begin
        next_phase = phase_inc;
      end
    end else begin
      next_tone_active = 1'b0;
      next_tone_out_pos = idle_level_sel;
      next_tone_out_neg = idle_level_sel;
      next_phase = 7'h00;
      if (pattern_sel == `PAT_SINGLE && single_seen && gate_prev) begin
        next_auto_stop = 1'b1;
      end
    end
  end
end

always @(posedge clock) begin
  if (rst) begin
    phase <= 7'h00;
    gate_prev <= 1'b0;
    single_seen <= 1'b0;
    auto_stop <= 1'b0;
    tone_active <= 1'b0;
    tone_out_pos <= 1'b0;
    tone_out_neg <= 1'b0;
  end else begin
    phase <= next_phase;
    gate_prev <= next_gate_prev;
    single_seen <= next_single_seen;
    auto_stop <= next_auto_stop;
    tone_active <= next_tone_active;
    tone_out_pos <= next_tone_out_pos;
    tone_out_neg <= next_tone_out_neg;
  end
end

endmodule // tone_generator

// ===== verification/tone_checker.sv
// Purpose: Port assertions of the tone generator
// Assumes: One clock domain
// Notes: Bound at the foot
`timescale 1ns/100ps
module tone_checker (
  input wire clock,
  input wire rst,
  input wire [17:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire tone_out_pos,
  input wire tone_out_neg,
  input wire tone_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req; (read || write) && waitrequest; endsequence
  sequence s_ans; !waitrequest ##1 waitrequest; endsequence
  wire [15:0] idx = address[17:2];
  wire took = read && !waitrequest;
  wire stop_wr = write && !waitrequest && idx == 16'hf0c0 && byteenable[0] && !writedata[0];
  a_stop_quiet:
    assert property (stop_wr |=> ##1 !tone_active && tone_out_pos == tone_out_neg)
      else $error("bad stop");
  a_one_wait: assert property (s_req |=> s_ans) else $error("bad wait");
  a_no_req: assert property (!read && !write |=> waitrequest) else $error("bad ack");
  a_data_hold: assert property (waitrequest |-> $stable(readdata)) else $error("bad hold");
  a_run_read:
    assert property (took && idx == 16'hf0c0 |-> readdata[31:1] == 0) else $error("bad run");
  a_cfg_read:
    assert property (took && idx == 16'hf0c2 |-> readdata[31:13] == 0) else $error("bad cfg");
  a_rsvd_read: assert property (took && idx == 16'hf0c1 |-> readdata == 0) else $error("bad rsv");
  a_phase_pair:
    assert property (tone_active |-> tone_out_neg != tone_out_pos) else $error("bad phase");
  a_idle_pair:
    assert property (!tone_active |-> tone_out_neg == tone_out_pos) else $error("bad idle");
endmodule // tone_checker
bind tone_generator tone_checker chk_i (.*);

// ===== verification/buzzer_model.sv
// Purpose: Piezo load across the tone pins
// Assumes: Push-pull drive
// Notes: Counts opposed swings
`timescale 1ns/100ps
module buzzer_model (
  input wire clock,
  input wire tone_out_pos,
  input wire tone_out_neg,
  output int edges = 0
);
  logic last;
  always @(posedge clock) begin
    last <= tone_out_pos;
    if (tone_out_pos !== tone_out_neg && tone_out_pos !== last) edges <= edges + 1;
  end
endmodule // buzzer_model

// ===== verification/buzzer_tone_generator_tb.sv
// Purpose: Bench of the tone generator
// Assumes: Enable every 4 clocks
// Notes: Rows play continuous tone
`timescale 1ns/100ps
module buzzer_tone_generator_tb;
  localparam int LS = 4;
  logic clock = 0, rst = 1, read = 0, write = 0, tick_eight_hz = 0, tick_one_hz = 0;
  logic [17:0] address = 0;
  logic [3:0] byteenable = 0;
  logic [31:0] writedata = 0, rdata;
  wire [31:0] readdata;
  wire waitrequest, tone_out_pos, tone_out_neg, tone_active;
  int error_cnt = 0, total_checks = 0, edges, n, h, l, e0;
  logic [15:0] cfg [9] = '{16'h0003, 16'h0f03, 16'h0013, 16'h0f23, 16'h0833, 16'h0143,
    16'h0253, 16'h0463, 16'h0373};
  int hi [9] = '{1, 7, 1, 30, 24, 4, 10, 24, 21};
  int per [9] = '{8, 8, 16, 32, 48, 64, 80, 96, 112};
  always #5 clock = ~clock;
  tone_generator #(.LS_HZ(32'h017d_7840)) dut (.*);
  buzzer_model load (.*);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic test_done(input int hang);
    error_cnt += hang;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d,
    input logic [3:0] b);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= b;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) test_done(1);
    rdata = readdata;
    write <= 0;
    read <= 0;
    @(posedge clock);
  endtask
  task automatic span(input logic v, output int c);
    c = 0;
    while (tone_out_pos === v && c < 999) begin
      @(posedge clock);
      c++;
    end
    if (c == 999) test_done(1);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      acc(1, 18'h3_c308, {16'h0, cfg[i]}, 4'h3);
      e0 = edges;
      acc(1, 18'h3_c300, 1, 4'h1);
      span(0, h);
      span(1, h);
      span(0, l);
      chk("high", hi[i] * LS, h);
      chk("period", per[i] * LS, h + l);
      chk("swings", 1, (edges - e0) >= 2);
      acc(1, 18'h3_c300, 0, 4'h1);
      @(posedge clock);
      chk("stop", 0, {tone_out_pos, tone_out_neg});
      $display("row %0d done", i);
    end
    acc(1, 18'h3_c308, 32'h0000_1000, 4'h2);
    @(posedge clock);
    chk("idle", 3, {tone_out_pos, tone_out_neg});
    acc(0, 18'h3_c308, 0, 4'h3);
    chk("lanes", 32'h0000_1073, rdata);
    for (int p = 0; p < 3; p++) begin
      acc(1, 18'h3_c308, p, 4'h1);
      acc(1, 18'h3_c300, 1, 4'h1);
      tick_eight_hz <= 1;
      repeat (12) @(posedge clock);
      chk("gate", p == 0, tone_active);
      tick_one_hz <= 1;
      repeat (7) @(posedge clock);
      chk("burst", 1, tone_active);
      tick_eight_hz <= 0;
      tick_one_hz <= 0;
      repeat (12) @(posedge clock);
      acc(0, 18'h3_c300, 0, 4'h1);
      chk("auto stop", p != 2, rdata);
      acc(1, 18'h3_c300, 0, 4'h1);
      $display("pattern %0d done", p);
    end
    rst <= 1;
    repeat (3) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (int k = 0; k < 4; k++) begin
      acc(0, 18'h3_c300 + 4 * k, 0, 4'hf);
      chk("reset", 0, rdata);
    end
    $display("reset done");
    test_done(0);
  end
endmodule // buzzer_tone_generator_tb
